/* otp_pkg.sv */
// Purpose: Shared constants and types for the security area block.
// Assumes: 100 MHz system clock and a mode 0 serial link.
// Notes:   Times are in microseconds; cycle counts derive from them.
`default_nettype none
package otp_pkg;
	// Clock rate and self-timed operation times.
	localparam int SYS_CLK_MHZ   = 100;
	localparam int ERASE_TIME_US = 100;
	localparam int PROG_TIME_US  = 10;
	localparam int ERASE_CYC     = ERASE_TIME_US * SYS_CLK_MHZ;
	localparam int PROG_CYC      = PROG_TIME_US * SYS_CLK_MHZ;
	localparam int AREA_BYTES    = 256;

	// Instruction codes.
	localparam logic [7:0] OP_WREN  = 8'h06;
	localparam logic [7:0] OP_WRDI  = 8'h04;
	localparam logic [7:0] OP_RDSR  = 8'h05;
	localparam logic [7:0] OP_ERASE = 8'h44;
	localparam logic [7:0] OP_PROG  = 8'h42;
	localparam logic [7:0] OP_READ  = 8'h48;
	localparam logic [7:0] OP_SFDP  = 8'h5A;

	// Rising-edge counts inside a frame.
	localparam logic [5:0] CNT_OPC   = 6'h07;
	localparam logic [5:0] CNT_ONE   = 6'h08;
	localparam logic [5:0] CNT_ADDR  = 6'h1F;
	localparam logic [5:0] CNT_ERASE = 6'h20;
	localparam logic [5:0] CNT_BYTE1 = 6'h27;
	localparam logic [5:0] CNT_DATA  = 6'h28;
	localparam logic [5:0] CNT_WRAP  = 6'h2F;

	// Address fields and data values.
	localparam logic [7:0] ADDR_TOP  = 8'h00;
	localparam logic [3:0] ADDR_MID  = 4'h0;
	localparam logic [7:0] ERASED    = 8'hFF;
	localparam logic [1:0] STAT_RST  = 2'h0;

	typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_PROG} sys_mode_t;

	// Link-side state, clocked by the serial clock.
	typedef struct packed {
		logic [5:0]  cnt;
		logic [7:0]  sh;
		logic [7:0]  opc;
		logic [23:0] addr;
		logic [7:0]  pg_byte;
		logic [7:0]  pg_at;
		logic [7:0]  pg_off;
		logic        pg_tgl;
		logic [23:0] rd_addr;
		logic        rd_tgl;
	} link_st_t;

	// System-side state.
	typedef struct packed {
		sys_mode_t   mode;
		logic [31:0] tmr;
		logic [1:0]  area;
		logic        write_enable_latch;
		logic        pg_seen;
		logic        pg_pend;
		logic [9:0]  pg_addr;
		logic [7:0]  pg_byte;
		logic        rd_pend;
		logic        rd_mem;
		logic [7:0]  rd_alt;
		logic [7:0]  rd_data;
		logic        cs_q;
		logic        pg_q;
		logic        rd_q;
	} sys_st_t;

	// One access to the area storage.
	typedef struct packed {
		logic       we;
		logic [9:0] addr;
		logic [7:0] wdata;
	} mem_req_t;

	// True when an address falls on one of the three areas.
	function automatic logic area_hit(input logic [23:0] a);
		area_hit = (a[23:16] == ADDR_TOP) && (a[11:8] == ADDR_MID) &&
			(a[13:12] == 2'h0) && (a[15:14] != 2'h0);
	endfunction

	// Area index 0..2 from address bits 15..14.
	function automatic logic [1:0] area_idx(input logic [23:0] a);
		area_idx = a[15:14] - 2'h1;
	endfunction

	// Tail of the discoverable parameter table; other bytes read FFh.
	function automatic logic [7:0] sfdp_byte(input logic [7:0] a);
		case (a)
			8'h96:   sfdp_byte = 8'h00;
			8'h9A:   sfdp_byte = 8'h00;
			8'h9C:   sfdp_byte = 8'h0C;
			8'h9D:   sfdp_byte = 8'h20;
			8'h9E:   sfdp_byte = 8'h0F;
			8'h9F:   sfdp_byte = 8'h52;
			8'hA0:   sfdp_byte = 8'h10;
			8'hA1:   sfdp_byte = 8'hD8;
			8'hA2:   sfdp_byte = 8'h00;
			default: sfdp_byte = ERASED;
		endcase
	endfunction
endpackage
`default_nettype wire

/* otp_sync.sv */
// Purpose: Two-flop synchroniser for a group of levels.
// Assumes: Each bit is a level or a toggle that holds for two clocks.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/10ps
`default_nettype none
module otp_sync #(
	parameter int               W   = 1,
	parameter logic [W-1:0]     RST = '0
) (
	input  wire logic           i_clk,
	input  wire logic           i_rst_n,
	input  wire logic [W-1:0]   i_d,
	output logic      [W-1:0]   o_q
);
	logic [W-1:0] meta_ff; // First stage, may go metastable.
	logic [W-1:0] q_ff;    // Second stage, safe to use.

	// Both stages load the reset pattern, then shift the input through.
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			meta_ff <= RST;
			q_ff    <= RST;
		end
		else
		begin
			meta_ff <= i_d;
			q_ff    <= meta_ff;
		end
	end

	assign o_q = q_ff;
endmodule
`default_nettype wire

/* otp_mem.sv */
// Purpose: Storage for the three security areas.
// Assumes: One access per clock, write or read.
// Notes:   Read data comes from a register one clock after the address.
`timescale 1ns/10ps
`default_nettype none
module otp_mem #(
	parameter int AW = 10,
	parameter int DW = 8
) (
	input  wire logic          i_clk,
	input  wire logic          i_we,
	input  wire logic [AW-1:0] i_addr,
	input  wire logic [DW-1:0] i_wdata,
	output logic      [DW-1:0] o_rdata
);
	logic [DW-1:0] mem [0:(1<<AW)-1]; // Cell array, no reset.
	logic [DW-1:0] rdata_ff;          // Registered read port.

	// A write stores; every access also returns the old contents.
	always_ff @(posedge i_clk)
	begin
		if (i_we)
		begin
			mem[i_addr] <= i_wdata;
		end
		rdata_ff <= mem[i_addr];
	end

	assign o_rdata = rdata_ff;
endmodule
`default_nettype wire

/* otp_access.sv */
// Purpose: Serial access to three one-time-lockable security areas.
// Assumes: Link in mode 0; lock bits come from status register two.
// Notes:   The serial clock only runs inside frames.
// What this block does
// - Three separate 256-byte areas, individually erased.
// - Erase accepted only while write enable set.
// - Address bits 15..14 select area; bits 23..16 and 13..8 fixed.
// - Erase runs only if frame ends on byte.
// - Erase is self-timed; status reads still answered.
// - Busy reads one for whole erase.
// - Erase completion clears the write enable latch.
// - Locked area ignores erase permanently.
// - Program 42h writes bytes onto erased cells.
// - Program accepted only while write enable set.
// - Locked area ignores program.
// - Opcode and address sampled on rising edges.
// - Read data changes on falling edges, MSB first.
// - Read offset wraps FFh to 00h within area.
// - Table lists erase sizes 0Ch,0Fh,10h with opcodes.
// - Fourth erase entry reads size 00h, opcode FFh.
// - Quad-everything mode entry reads zero and FFh.
`timescale 1ns/10ps
`default_nettype none
module otp_access
	import otp_pkg::*;
#(
	parameter int ERASE_CYCLES = ERASE_CYC,
	parameter int PROG_CYCLES  = PROG_CYC
) (
	input  wire logic       i_sys_clk,
	input  wire logic       i_rst_n,
	input  wire logic       i_sclk,
	input  wire logic       i_cs_n,
	input  wire logic       i_si,
	input  wire logic [2:0] i_security_area_lock_bits,
	output logic            o_so,
	output logic            o_so_oe,
	output logic            o_busy,
	output logic            o_write_enable_latch
);
	// Link-domain state and its next value.
	link_st_t    lk_ff;
	link_st_t    nxt_lk;
	logic        frm_ff;     // High once the frame has seen an edge.
	logic        frm_clr;    // Ends a frame or holds it under reset.
	logic [5:0]  cur_cnt;    // Edge count seen by this rising edge.
	logic [7:0]  byte_in;    // Shift register including this bit.
	logic        is_read;    // Current opcode returns stored data.
	logic [7:0]  so_sh_ff;   // Falling-edge output shifter.
	logic        so_act_ff;  // Output phase has begun.
	logic        ld_stat;    // Load a status byte at this edge.
	logic        ld_data;    // Load a data byte at this edge.
	logic [1:0]  stat_lk;    // Latch and busy seen on link side.

	// System-domain state, synchronised inputs and storage port.
	sys_st_t     sy_ff;
	sys_st_t     nxt_sy;
	logic [2:0]  xs_sync;    // Select, program and read events.
	logic        cs_s;
	logic        pg_s;
	logic        rd_s;
	logic        cs_rise;
	logic        pg_evt;
	logic        rd_evt;
	logic        pg_ok;
	logic        idle;
	logic [1:0]  er_idx;
	mem_req_t    mreq;
	logic [7:0]  mem_rdata;

	// A frame ends when select rises; reset also clears frame logic.
	assign frm_clr = i_cs_n | ~i_rst_n;

	// Marks the first edge of a frame so the count restarts.
	always_ff @(posedge i_sclk or posedge frm_clr)
	begin
		if (frm_clr)
		begin
			frm_ff <= 1'b0;
		end
		else
		begin
			frm_ff <= 1'b1;
		end
	end

	assign is_read = (lk_ff.opc == OP_READ) || (lk_ff.opc == OP_SFDP);

	// Rising-edge decoder: bits are sampled here only.
	always_comb
	begin
		nxt_lk  = lk_ff;
		cur_cnt = frm_ff ? lk_ff.cnt : 6'h00;
		byte_in = {lk_ff.sh[6:0], i_si};
		if (!i_cs_n)
		begin
			nxt_lk.sh = byte_in;
			// Count wraps inside the data phase so byte marks repeat.
			if (cur_cnt == CNT_WRAP)
			begin
				nxt_lk.cnt = CNT_DATA;
			end
			else
			begin
				nxt_lk.cnt = cur_cnt + 6'h01;
			end
			// The opcode is complete on the eighth edge.
			if (cur_cnt == CNT_OPC)
			begin
				nxt_lk.opc = byte_in;
			end
			// The next three bytes form the address.
			if ((cur_cnt > CNT_OPC) && (cur_cnt <= CNT_ADDR))
			begin
				nxt_lk.addr = {lk_ff.addr[22:0], i_si};
			end
			// Last address bit: fetch the first read byte early.
			if (cur_cnt == CNT_ADDR)
			begin
				nxt_lk.pg_off = byte_in;
				if (is_read)
				begin
					nxt_lk.rd_addr = {lk_ff.addr[22:0], i_si};
					nxt_lk.rd_tgl  = ~lk_ff.rd_tgl;
				end
			end
			// Each loaded byte asks for the next; low byte wraps.
			if (is_read && (cur_cnt >= CNT_DATA) && (cur_cnt[2:0] == 3'h0))
			begin
				nxt_lk.rd_addr[7:0] = lk_ff.rd_addr[7:0] + 8'h01;
				nxt_lk.rd_tgl       = ~lk_ff.rd_tgl;
			end
			// Each whole data byte of a program is handed over.
			if ((lk_ff.opc == OP_PROG) && (cur_cnt >= CNT_BYTE1) &&
				(cur_cnt[2:0] == 3'h7))
			begin
				nxt_lk.pg_byte = byte_in;
				nxt_lk.pg_at   = lk_ff.pg_off;
				nxt_lk.pg_off  = lk_ff.pg_off + 8'h01;
				nxt_lk.pg_tgl  = ~lk_ff.pg_tgl;
			end
		end
	end

	// Link-side register; held while select is high.
	always_ff @(posedge i_sclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			lk_ff <= '0;
		end
		else
		begin
			lk_ff <= nxt_lk;
		end
	end

	// Status bits brought onto the serial clock for status reads.
	otp_sync #(
		.W   (2),
		.RST (STAT_RST)
	) u_stat_sync (
		.i_clk   (i_sclk),
		.i_rst_n (i_rst_n),
		.i_d     ({sy_ff.write_enable_latch, o_busy}),
		.o_q     (stat_lk)
	);

	// Byte loads happen at falling edges on byte marks.
	assign ld_stat = frm_ff && (lk_ff.opc == OP_RDSR) &&
		(lk_ff.cnt >= CNT_ONE) && (lk_ff.cnt[2:0] == 3'h0);
	assign ld_data = frm_ff && is_read && (lk_ff.cnt >= CNT_DATA) &&
		(lk_ff.cnt[2:0] == 3'h0);

	// Output shifter. Read data was requested a byte earlier and
	// has stood still for several system clocks when it is loaded.
	always_ff @(negedge i_sclk or posedge frm_clr)
	begin
		if (frm_clr)
		begin
			so_sh_ff  <= 8'h00;
			so_act_ff <= 1'b0;
		end
		else if (ld_stat)
		begin
			so_sh_ff  <= {6'h00, stat_lk};
			so_act_ff <= 1'b1;
		end
		else if (ld_data)
		begin
			so_sh_ff  <= sy_ff.rd_data;
			so_act_ff <= 1'b1;
		end
		else
		begin
			so_sh_ff <= {so_sh_ff[6:0], 1'b0};
		end
	end

	// Most significant bit leaves first; driven only while selected.
	assign o_so    = so_sh_ff[7];
	assign o_so_oe = so_act_ff & ~i_cs_n;

	// Select and both event toggles enter the system clock.
	otp_sync #(
		.W   (3),
		.RST (3'h1)
	) u_evt_sync (
		.i_clk   (i_sys_clk),
		.i_rst_n (i_rst_n),
		.i_d     ({lk_ff.rd_tgl, lk_ff.pg_tgl, i_cs_n}),
		.o_q     (xs_sync)
	);

	assign cs_s    = xs_sync[0];
	assign pg_s    = xs_sync[1];
	assign rd_s    = xs_sync[2];
	assign cs_rise = cs_s & ~sy_ff.cs_q;
	assign pg_evt  = pg_s ^ sy_ff.pg_q;
	assign rd_evt  = rd_s ^ sy_ff.rd_q;
	assign idle    = (sy_ff.mode == ST_IDLE);
	assign er_idx  = area_idx(lk_ff.addr);

	// A program byte is taken only for an unlocked area with the
	// latch set; link fields are stable once the toggle is seen.
	assign pg_ok = pg_evt && idle && sy_ff.write_enable_latch &&
		(lk_ff.opc == OP_PROG) && area_hit(lk_ff.addr) &&
		!i_security_area_lock_bits[er_idx];

	// System-side sequencing of storage, timers and the latch.
	always_comb
	begin
		nxt_sy      = sy_ff;
		mreq        = '0;
		nxt_sy.cs_q = cs_s;
		nxt_sy.pg_q = pg_s;
		nxt_sy.rd_q = rd_s;
		// Storage port: pending program write first, then new work.
		if (sy_ff.pg_pend)
		begin
			// Programming can only clear bits of an erased cell.
			mreq.we        = 1'b1;
			mreq.addr      = sy_ff.pg_addr;
			mreq.wdata     = mem_rdata & sy_ff.pg_byte;
			nxt_sy.pg_pend = 1'b0;
		end
		else if (pg_ok)
		begin
			mreq.addr      = {er_idx, lk_ff.pg_at};
			nxt_sy.pg_addr = {er_idx, lk_ff.pg_at};
			nxt_sy.pg_byte = lk_ff.pg_byte;
			nxt_sy.pg_pend = 1'b1;
			nxt_sy.pg_seen = 1'b1;
		end
		else if (rd_evt)
		begin
			// Busy or off-area reads return erased data.
			nxt_sy.rd_pend = 1'b1;
			nxt_sy.rd_mem  = idle && (lk_ff.opc == OP_READ) &&
				area_hit(lk_ff.rd_addr);
			mreq.addr      = {area_idx(lk_ff.rd_addr),
				lk_ff.rd_addr[7:0]};
			if (idle && (lk_ff.opc == OP_SFDP))
			begin
				nxt_sy.rd_alt = sfdp_byte(lk_ff.rd_addr[7:0]);
			end
			else
			begin
				nxt_sy.rd_alt = ERASED;
			end
		end
		// A read that arrives during an erase returns FFh and never
		// uses the port, so the fill takes the port and no cell is
		// skipped; the read request itself is still recorded above.
		if ((sy_ff.mode == ST_ERASE) &&
			(sy_ff.tmr < AREA_BYTES))
		begin
			// The first clocks of an erase fill the area with FFh.
			mreq.we    = 1'b1;
			mreq.addr  = {sy_ff.area, sy_ff.tmr[7:0]};
			mreq.wdata = ERASED;
		end
		// Read data lands one clock after its address.
		if (sy_ff.rd_pend)
		begin
			nxt_sy.rd_pend = 1'b0;
			nxt_sy.rd_data = sy_ff.rd_mem ? mem_rdata : sy_ff.rd_alt;
		end
		// A byte that lands in the same clock as select rising wins,
		// so the program still starts its busy stretch.
		if (cs_rise && !pg_ok)
		begin
			nxt_sy.pg_seen = 1'b0;
		end
		// Mode sequencing; busy states ignore latch, erase and program instructions.
		case (sy_ff.mode)
			ST_IDLE:
			begin
				if (cs_rise && (lk_ff.cnt == CNT_ONE) &&
					(lk_ff.opc == OP_WREN))
				begin
					nxt_sy.write_enable_latch = 1'b1;
				end
				else if (cs_rise && (lk_ff.cnt == CNT_ONE) &&
					(lk_ff.opc == OP_WRDI))
				begin
					nxt_sy.write_enable_latch = 1'b0;
				end
				else if (cs_rise && (lk_ff.opc == OP_ERASE) &&
					(lk_ff.cnt == CNT_ERASE) &&
					sy_ff.write_enable_latch && area_hit(lk_ff.addr) &&
					!i_security_area_lock_bits[er_idx])
				begin
					nxt_sy.mode = ST_ERASE;
					nxt_sy.tmr  = 32'h0;
					nxt_sy.area = er_idx;
				end
				else if (cs_rise && (lk_ff.opc == OP_PROG) &&
					(sy_ff.pg_seen || pg_ok))
				begin
					nxt_sy.mode = ST_PROG;
					nxt_sy.tmr  = 32'h0;
				end
			end
			ST_ERASE:
			begin
				// Busy holds until the full erase time has run.
				nxt_sy.tmr = sy_ff.tmr + 32'h1;
				if (sy_ff.tmr == 32'(ERASE_CYCLES - 1))
				begin
					nxt_sy.mode = ST_IDLE;
					nxt_sy.write_enable_latch  = 1'b0;
				end
			end
			ST_PROG:
			begin
				nxt_sy.tmr = sy_ff.tmr + 32'h1;
				if (sy_ff.tmr == 32'(PROG_CYCLES - 1))
				begin
					nxt_sy.mode = ST_IDLE;
					nxt_sy.write_enable_latch  = 1'b0;
				end
			end
			default:
			begin
				nxt_sy.mode = ST_IDLE;
			end
		endcase
	end

	// System-side register.
	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			sy_ff      <= '0;
			sy_ff.cs_q <= 1'b1;
		end
		else
		begin
			sy_ff <= nxt_sy;
		end
	end

	// Area storage, three areas in one array.
	otp_mem #(
		.AW (10),
		.DW (8)
	) u_mem (
		.i_clk   (i_sys_clk),
		.i_we    (mreq.we),
		.i_addr  (mreq.addr),
		.i_wdata (mreq.wdata),
		.o_rdata (mem_rdata)
	);

	assign o_busy               = (sy_ff.mode != ST_IDLE);
	assign o_write_enable_latch = sy_ff.write_enable_latch;
endmodule
`default_nettype wire

/* otp_access_asserts.sv */
// Purpose: Port-level checks for the security area block.
// Assumes: All checks run on the system clock.
// Notes:   Bound to every instance of the block.
`timescale 1ns/10ps
`default_nettype none
module otp_access_asserts #(
	parameter int ERASE_CYCLES = 10000,
	parameter int PROG_CYCLES  = 1000
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_sclk,
	input wire logic i_cs_n,
	input wire logic o_so,
	input wire logic o_so_oe,
	input wire logic o_busy,
	input wire logic o_write_enable_latch
);
	// Length of the current busy stretch, in system clocks.
	int unsigned busy_cnt_ff;

	// The count restarts whenever busy is low.
	always_ff @(posedge i_sys_clk or negedge i_rst_n)
		if (!i_rst_n)
			busy_cnt_ff <= '0;
		else
			busy_cnt_ff <= o_busy ? busy_cnt_ff + 1 : '0;

	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rst_n);

	oe_cs_off_a: assert property (i_cs_n |-> !o_so_oe)
		else $error("output enabled while select is high");
	so_fall_a: assert property ($changed(o_so) |-> !i_sclk)
		else $error("output bit changed away from a falling edge");
	oe_rise_a: assert property ($rose(o_so_oe) |-> !i_sclk && !i_cs_n)
		else $error("output phase began at the wrong moment");
	busy_cs_high_a: assert property ($rose(o_busy) |-> i_cs_n && $past(i_cs_n))
		else $error("busy rose inside a frame");
	busy_wel_a: assert property ($rose(o_busy) |-> $past(o_write_enable_latch))
		else $error("busy rose without the write enable latch");
	busy_keeps_wel_a: assert property (o_busy |-> o_write_enable_latch)
		else $error("latch dropped during a busy stretch");
	busy_end_wel_a: assert property ($fell(o_busy) |-> !o_write_enable_latch)
		else $error("latch still set after completion");
	busy_len_a: assert property ($fell(o_busy) |-> busy_cnt_ff == ERASE_CYCLES || busy_cnt_ff == PROG_CYCLES)
		else $error("busy stretch has the wrong length");
	wel_rise_a: assert property ($rose(o_write_enable_latch) |-> i_cs_n && !o_busy)
		else $error("latch set inside a frame or while busy");
endmodule

bind otp_access otp_access_asserts #(
	.ERASE_CYCLES(ERASE_CYCLES),
	.PROG_CYCLES(PROG_CYCLES)
) i_chk (.i_sys_clk, .i_rst_n, .i_sclk, .i_cs_n, .o_so, .o_so_oe,
	.o_busy, .o_write_enable_latch);
`default_nettype wire

/* spi_host_model.sv */
// Purpose: Host controller model driving the serial link in mode 0.
// Assumes: Link period 80 ns, edges held 3 ns off the system clock edges.
// Notes:   The link clock stands still low between frames.
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
	input  wire logic       i_so,
	output logic            o_sclk,
	output logic            o_cs_n,
	output logic            o_si,
	output logic      [7:0] o_rx_byte,
	output logic            o_rx_stb
);
	logic rclk; // Free reference, passed to the link only in frames.

	// The 3 ns offset keeps link edges clear of system clock edges.
	initial
	begin
		{o_sclk, o_cs_n, o_si, o_rx_byte, o_rx_stb} = 12'h400;
		rclk = 1'b0;
		#3;
		forever #40 rclk = ~rclk;
	end

	// One frame: n bits from the top of v, then nrd bytes read back.
	// Select stays low over every bit and rises only after the last.
	task automatic frame(input logic [63:0] v, input int n, input int nrd);
		logic [7:0] b;
		b = 8'h00;
		@(negedge rclk) o_cs_n = 1'b0;
		for (int i = 0; i < n + nrd * 8; i++)
		begin
			@(negedge rclk) o_sclk = 1'b0;
			o_si = (i < n) ? v[63 - i] : ~o_si;
			@(posedge rclk) b = {b[6:0], i_so};
			o_sclk = 1'b1;
			if (i >= n && (i - n) % 8 == 7)
			begin
				o_rx_byte = b;
				o_rx_stb = ~o_rx_stb;
			end
		end
		@(negedge rclk) o_sclk = 1'b0;
		@(posedge rclk) o_cs_n = 1'b1;
		o_si = ~o_si; // Released line: no stale value.
		#100;
	endtask
endmodule
`default_nettype wire

/* testbench.sv */
// Purpose: Self-checking bench for the security area block.
// Assumes: Short erase and program times set through parameters.
// Notes:   Read bytes are matched against a queue of expected values.
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import otp_pkg::*;
	logic         clk = 1'b0;   // System clock, 100 MHz.
	logic         rst_n = 1'b0; // Reset, active low.
	logic [2:0]   lock = 3'h0;  // Per-area lock bits.
	logic         sclk, cs_n, si, so, so_oe, busy, write_enable_latch, stb;
	logic [7:0]   rx;           // Byte just collected by the host.
	logic [7:0]   exp_q[$];     // Expected read bytes, oldest first.
	logic [7:0]   d[3];         // Random program data.
	logic [111:0] tbl;          // Parameter table tail, 96h first.
	int           errors = 0;
	int           checked = 0;
	int           cyc = 0;

	always #5 clk = ~clk;

	otp_access #(.ERASE_CYCLES(300), .PROG_CYCLES(20)) i_dut (
		.i_sys_clk(clk), .i_rst_n(rst_n), .i_sclk(sclk), .i_cs_n(cs_n),
		.i_si(si), .i_security_area_lock_bits(lock), .o_so(so),
		.o_so_oe(so_oe), .o_busy(busy), .o_write_enable_latch(write_enable_latch));

	// An undriven output reads as high impedance, so a missing enable shows.
	spi_host_model i_host (.i_so(so_oe ? so : 1'bz), .o_sclk(sclk),
		.o_cs_n(cs_n), .o_si(si), .o_rx_byte(rx), .o_rx_stb(stb));

	task automatic close_out();
		if (errors == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic check(input string nm, input logic [7:0] seen, want);
		checked++;
		if (seen !== want)
		begin
			errors++;
			$display("unexpected %s expected %h seen %h", nm, want, seen);
		end
	endtask

	// Each byte the host collects is matched with the oldest note.
	always @(stb)
		if (exp_q.size() > 0)
			check("read byte", rx, exp_q.pop_front());

	task automatic flags(input logic b, input logic w);
		check("busy", {7'h00, busy}, {7'h00, b});
		check("latch", {7'h00, write_enable_latch}, {7'h00, w});
	endtask

	task automatic wren();
		i_host.frame({OP_WREN, 56'h0}, 8, 0);
	endtask

	// Bounded wait; completion must leave both flags clear.
	task automatic wait_idle();
		for (int k = 0; k < 2000 && busy !== 1'b0; k++)
			@(posedge clk);
		flags(1'b0, 1'b0);
	endtask

	// Erase one area with a random ignored low byte; status mid-erase.
	task automatic erase(input logic [1:0] a);
		wren();
		i_host.frame({OP_ERASE, 8'h00, a, 6'h00, 8'($urandom), 32'h0}, 32, 0);
		flags(1'b1, 1'b1);
		exp_q.push_back(8'h03);
		i_host.frame({OP_RDSR, 56'h0}, 8, 1);
		wait_idle();
	endtask

	task automatic prog(input logic [15:0] at, input logic [7:0] v);
		i_host.frame({OP_PROG, 8'h00, at, v, 24'h0}, 40, 0);
	endtask

	initial
	begin
		void'($urandom(32'h277C));
		repeat (10) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		flags(1'b0, 1'b0);
		// Erase without the latch set is ignored.
		i_host.frame({OP_ERASE, 24'h004000, 32'h0}, 32, 0);
		flags(1'b0, 1'b0);
		// Select rising one bit past the byte boundary cancels erase.
		wren();
		i_host.frame({OP_ERASE, 24'h004000, 32'h0}, 33, 0);
		flags(1'b0, 1'b1);
		for (int a = 1; a < 4; a++)
			erase(a[1:0]);
		prog(16'h4001, 8'h00);
		flags(1'b0, 1'b0);
		// Area two locked: erase and program are both ignored.
		@(negedge clk) lock = 3'h2;
		wren();
		i_host.frame({OP_ERASE, 24'h008000, 32'h0}, 32, 0);
		flags(1'b0, 1'b1);
		prog(16'h8000, 8'h00);
		flags(1'b0, 1'b1);
		// Program the last two bytes and the first of area one.
		for (int i = 0; i < 3; i++)
		begin
			d[i] = 8'($urandom);
			wren();
			prog({8'h40, 8'hFE + 8'(i)}, d[i]);
			flags(1'b1, 1'b1);
			wait_idle();
		end
		erase(2'h3);
		foreach (d[i])
			exp_q.push_back(d[i]);
		exp_q.push_back(8'hFF);
		i_host.frame({OP_READ, 24'h0040FE, 32'h0}, 40, 4);
		exp_q.push_back(8'hFF);
		i_host.frame({OP_READ, 24'h008000, 32'h0}, 40, 1);
		tbl = 112'h00FFFFFF00FF0C200F5210D800FF;
		for (int i = 13; i >= 0; i--)
			exp_q.push_back(tbl[i * 8 +: 8]);
		i_host.frame({OP_SFDP, 24'h000096, 32'h0}, 40, 14);
		check("notes left", 8'(exp_q.size()), 8'h00);
		close_out();
	end

	// Hang guard: the run needs about 8000 system clocks.
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			errors++;
			close_out();
		end
	end
endmodule
`default_nettype wire
